// >>> rtl/iec_checker.sv
// dual-port double-rate input sample error checker with its registers
// Notes on behaviour
// - compare only while enable bit 7 set
// - bit 6 flags error seen on port b
// - bit 5 flags error seen on port a
// - auto-clear after eight good sets when bit 3
// - bit 2 shows last port b set failed
// - bit 1 shows last port a set failed
// - bit 0 shows last set passed
// - rising-edge error map at 0x41/0x42
// - falling-edge error map at 0x43/0x44
// - port select picks which maps are read
// - words 0,2 rising edge; 1,3 falling edge
// - port select picks pattern write target
`timescale 1ns/1ps
`default_nettype none
`include "iec_params.svh"
module iec_checker (
  input  wire logic        i_sys_clk,
  input  wire logic        i_reset,
  input  wire logic        i_input_data_clock,
  input  wire logic [15:0] i_port_a_data,
  input  wire logic [15:0] i_port_b_data,
  input  wire logic        i_port_select,
  input  wire logic        i_spi_clk,
  input  wire logic        i_spi_cs_n,
  input  wire logic        i_spi_sdi,
  output logic             o_spi_sdo,
  output logic             o_spi_sdo_oe
);
  logic [6:0]  addr;
  logic [7:0]  wdata;
  logic        wr_stb;
  logic [7:0]  rdata;
  logic        ctl_enable;
  logic        ctl_auto;
  logic        sel_m;
  logic        sel_s;
  logic        dci_m;
  logic        dci_s;
  logic        dci_q;
  logic [15:0] data_m [0:1];
  logic [15:0] data_s [0:1];
  logic [15:0] pat    [0:1][0:3];
  logic [15:0] map_r  [0:1];
  logic [15:0] map_f  [0:1];
  logic [1:0]  set_fail;
  logic [1:0]  stat_fail;
  logic [1:0]  err_det;
  logic        stat_pass;
  logic [1:0]  idx;
  logic [3:0]  pass_cnt;
  logic [1:0]  fail_now;

  iec_spi_port u_spi (
    .i_sys_clk    (i_sys_clk),
    .i_reset      (i_reset),
    .i_spi_clk    (i_spi_clk),
    .i_spi_cs_n   (i_spi_cs_n),
    .i_spi_sdi    (i_spi_sdi),
    .i_rdata      (rdata),
    .o_addr       (addr),
    .o_wdata      (wdata),
    .o_wr_stb     (wr_stb),
    .o_spi_sdo    (o_spi_sdo),
    .o_spi_sdo_oe (o_spi_sdo_oe)
  );

  // data is synchronised with the same latency as the clock so they align
  always_ff @(posedge i_sys_clk or posedge i_reset)
    if (i_reset)
    begin
      {dci_m, dci_s, dci_q, sel_m, sel_s} <= 5'h00;
      data_m <= '{16'h0000, 16'h0000};
      data_s <= '{16'h0000, 16'h0000};
    end
    else
    begin
      dci_m  <= i_input_data_clock;
      dci_s  <= dci_m;
      dci_q  <= dci_s;
      sel_m  <= i_port_select;
      sel_s  <= sel_m;
      data_m <= '{i_port_a_data, i_port_b_data};
      data_s <= data_m;
    end

  wire dci_rise  = dci_s & ~dci_q;
  wire dci_fall  = ~dci_s & dci_q;
  // a set only starts on a rising edge; odd slots take falling edges
  wire edge_ok   = ctl_enable & (idx[0] ? dci_fall : dci_rise);
  wire set_done  = edge_ok & (idx == 2'h3);
  wire set_pass  = ~(fail_now[0] | fail_now[1]);
  wire auto_clr  = ctl_auto & set_done & set_pass &
                   (pass_cnt == `IEC_AUTO_SETS - 4'h1);
  wire ctl_wr    = wr_stb & (addr == `IEC_ADDR_CTL);
  wire pat_hit   = (addr[6:3] == 4'(`IEC_ADDR_PAT_BASE >> 3));
  wire pat_wr    = wr_stb & pat_hit;

  genvar p;
  generate
    for (p = 0; p < 2; p = p + 1)
    begin : g_port
      wire [15:0] miss = data_s[p] ^ pat[p][idx];
      assign fail_now[p] = set_fail[p] | (|miss);
      always_ff @(posedge i_sys_clk or posedge i_reset)
        if (i_reset)
        begin
          map_r[p]     <= 16'h0000;
          map_f[p]     <= 16'h0000;
          set_fail[p]  <= 1'b0;
          stat_fail[p] <= 1'b0;
          err_det[p]   <= 1'b0;
        end
        else if (!ctl_enable || auto_clr)
        begin
          // disabling the checker wipes its history
          map_r[p]     <= 16'h0000;
          map_f[p]     <= 16'h0000;
          set_fail[p]  <= 1'b0;
          err_det[p]   <= 1'b0;
          stat_fail[p] <= ctl_enable & stat_fail[p] & ~set_done;
        end
        else if (edge_ok)
        begin
          if (idx[0])
            map_f[p] <= map_f[p] | miss;
          else
            map_r[p] <= map_r[p] | miss;
          set_fail[p] <= set_done ? 1'b0 : fail_now[p];
          if (set_done)
          begin
            stat_fail[p] <= fail_now[p];
            err_det[p]   <= err_det[p] | fail_now[p];
          end
        end
    end
  endgenerate

  always_ff @(posedge i_sys_clk or posedge i_reset)
    if (i_reset)
    begin
      ctl_enable <= 1'(`IEC_CTL_RESET >> `IEC_BIT_ENABLE);
      ctl_auto   <= 1'b0;
      idx        <= 2'h0;
      pass_cnt   <= 4'h0;
      stat_pass  <= 1'b0;
      for (int q = 0; q < 2; q++)
        for (int w = 0; w < 4; w++)
          pat[q][w] <= `IEC_PAT_RESET;
    end
    else
    begin
      if (ctl_wr)
      begin
        ctl_enable <= wdata[`IEC_BIT_ENABLE];
        ctl_auto   <= wdata[`IEC_BIT_AUTO];
      end
      if (pat_wr && addr[0])
        pat[sel_s][addr[2:1]][15:8] <= wdata;
      if (pat_wr && !addr[0])
        pat[sel_s][addr[2:1]][7:0] <= wdata;
      if (!ctl_enable)
      begin
        idx       <= 2'h0;
        pass_cnt  <= 4'h0;
        stat_pass <= 1'b0;
      end
      else if (edge_ok)
      begin
        idx <= idx + 2'h1;
        if (set_done)
        begin
          stat_pass <= set_pass;
          // counts consecutive good sets; a failing set restarts it
          // saturates so a late auto-clear enable still sees the run
          pass_cnt  <= (!set_pass || auto_clr) ? 4'h0 :
                       (pass_cnt == `IEC_AUTO_SETS - 4'h1) ? pass_cnt :
                       pass_cnt + 4'h1;
        end
      end
    end

  wire [7:0] ctl_rd = {ctl_enable, err_det[1], err_det[0], 1'b0,
                       ctl_auto, stat_fail[1], stat_fail[0], stat_pass};
  wire [15:0] rmap = map_r[sel_s];
  wire [15:0] fmap = map_f[sel_s];
  wire [15:0] pword = pat[sel_s][addr[2:1]];
  wire [7:0] pat_rd = addr[0] ? pword[15:8] : pword[7:0];
  assign rdata = (addr == `IEC_ADDR_CTL)      ? ctl_rd :
                 (addr == `IEC_ADDR_MAP_R_LO) ? rmap[7:0] :
                 (addr == `IEC_ADDR_MAP_R_HI) ? rmap[15:8] :
                 (addr == `IEC_ADDR_MAP_F_LO) ? fmap[7:0] :
                 (addr == `IEC_ADDR_MAP_F_HI) ? fmap[15:8] :
                 pat_hit ? pat_rd : 8'h00;

  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_reset);

  sequence s_set_end;
    set_done && !auto_clr;
  endsequence

  sequence s_good_set;
    set_done && set_pass;
  endsequence

  a_disabled_clears: assert property (
    !ctl_enable |=> !err_det[0] && !err_det[1] && idx == 2'h0
  ) else $error("status not cleared while disabled");
  a_port_b_detect: assert property (
    s_set_end ##0 fail_now[1] |=>
      err_det[1] ##1 (err_det[1] || !$past(ctl_enable))
  ) else $error("port b error not flagged");
  a_port_a_detect: assert property (
    s_set_end ##0 fail_now[0] |=> err_det[0]
  ) else $error("port a error not flagged");
  a_auto_clear: assert property (
    s_good_set ##0 ctl_auto && pass_cnt == 4'h7 |=> !err_det[0] && !err_det[1]
  ) else $error("auto clear missed");
  a_fail_b_last: assert property (
    set_done ##1 ctl_enable |-> stat_fail[1] == $past(fail_now[1])
  ) else $error("port b fail status wrong");
  a_fail_a_last: assert property (
    set_done ##1 ctl_enable |-> stat_fail[0] == $past(fail_now[0])
  ) else $error("port a fail status wrong");
  a_pass_excl: assert property (
    stat_pass |-> !stat_fail[0] && !stat_fail[1]
  ) else $error("pass and fail both set");
  a_map_sticky: assert property (
    ctl_enable && !auto_clr ##1 ctl_enable |->
      (map_r[0] & $past(map_r[0])) == $past(map_r[0])
  ) else $error("rising map bit lost");
  a_map_readsel: assert property (
    addr == `IEC_ADDR_MAP_F_HI |-> rdata == map_f[sel_s][15:8]
  ) else $error("map read from wrong port");
endmodule // iec_checker
`default_nettype wire

// >>> rtl/iec_params.svh
// register offsets, field positions and reset values of the checker
`ifndef IEC_PARAMS_SVH
`define IEC_PARAMS_SVH
`define IEC_ADDR_PAT_BASE  7'h38
`define IEC_ADDR_CTL       7'h40
`define IEC_ADDR_MAP_R_LO  7'h41
`define IEC_ADDR_MAP_R_HI  7'h42
`define IEC_ADDR_MAP_F_LO  7'h43
`define IEC_ADDR_MAP_F_HI  7'h44
`define IEC_BIT_ENABLE     7
`define IEC_BIT_DET_B      6
`define IEC_BIT_DET_A      5
`define IEC_BIT_AUTO       3
`define IEC_BIT_FAIL_B     2
`define IEC_BIT_FAIL_A     1
`define IEC_BIT_PASS       0
`define IEC_CTL_RESET      8'h00
`define IEC_PAT_RESET      16'h0000
`define IEC_AUTO_SETS      4'h8
`endif

// >>> rtl/iec_pkg.sv
// types shared by the checker files
package iec_pkg;
  typedef enum logic [1:0] {
    IEC_IDLE,
    IEC_INSTR,
    IEC_DATA,
    IEC_DONE
  } iec_spi_state_e;
endpackage

// >>> rtl/iec_spi_port.sv
// serial configuration port slave, sampled by the system clock
`timescale 1ns/1ps
`default_nettype none
module iec_spi_port (
  input  wire logic       i_sys_clk,
  input  wire logic       i_reset,
  input  wire logic       i_spi_clk,
  input  wire logic       i_spi_cs_n,
  input  wire logic       i_spi_sdi,
  input  wire logic [7:0] i_rdata,
  output logic      [6:0] o_addr,
  output logic      [7:0] o_wdata,
  output logic            o_wr_stb,
  output logic            o_spi_sdo,
  output logic            o_spi_sdo_oe
);
  logic [2:0] sync_m;
  logic [2:0] sync_s;
  logic       clk_q;
  iec_pkg::iec_spi_state_e state;
  logic [3:0]  cnt;
  logic [6:0]  shreg;
  logic        rd;
  logic        load_pend;
  logic [7:0]  out_sh;
  wire         clk_s = sync_s[0];
  wire         cs_n_s = sync_s[1];
  wire         sdi_s = sync_s[2];
  wire         clk_rise = clk_s & ~clk_q;
  wire         clk_fall = ~clk_s & clk_q;
  wire  [7:0]  word_in = {shreg, sdi_s};

  // pins cross two flops before any logic looks at them
  always_ff @(posedge i_sys_clk or posedge i_reset)
    if (i_reset)
    begin
      // chip select idles high so no false frame start follows reset
      sync_m <= 3'h2;
      sync_s <= 3'h2;
      clk_q  <= 1'b0;
    end
    else
    begin
      sync_m <= {i_spi_sdi, i_spi_cs_n, i_spi_clk};
      sync_s <= sync_m;
      clk_q  <= clk_s;
    end

  always_ff @(posedge i_sys_clk or posedge i_reset)
    if (i_reset)
    begin
      state     <= iec_pkg::IEC_IDLE;
      cnt       <= 4'h0;
      shreg     <= 7'h00;
      rd        <= 1'b0;
      load_pend <= 1'b0;
      out_sh    <= 8'h00;
      o_addr    <= 7'h00;
      o_wdata   <= 8'h00;
      o_wr_stb  <= 1'b0;
      o_spi_sdo <= 1'b0;
    end
    else
    begin
      o_wr_stb  <= 1'b0;
      load_pend <= 1'b0;
      if (load_pend)
        out_sh <= i_rdata;
      if (cs_n_s)
        state <= iec_pkg::IEC_IDLE;
      else
        case (state)
          iec_pkg::IEC_IDLE:
          begin
            state <= iec_pkg::IEC_INSTR;
            cnt   <= 4'h0;
          end
          iec_pkg::IEC_INSTR:
            if (clk_rise)
            begin
              shreg <= word_in[6:0];
              cnt   <= cnt + 4'h1;
              if (cnt == 4'h7)
              begin
                // instruction byte: read flag then 7-bit address
                rd        <= word_in[7];
                o_addr    <= word_in[6:0];
                load_pend <= word_in[7];
                state     <= iec_pkg::IEC_DATA;
              end
            end
          iec_pkg::IEC_DATA:
          begin
            if (clk_fall && rd)
            begin
              o_spi_sdo <= out_sh[7];
              out_sh    <= {out_sh[6:0], 1'b0};
            end
            if (clk_rise)
            begin
              shreg <= word_in[6:0];
              cnt   <= cnt + 4'h1;
              if (cnt == 4'hf)
              begin
                o_wdata  <= word_in;
                o_wr_stb <= ~rd;
                state    <= iec_pkg::IEC_DONE;
              end
            end
          end
          iec_pkg::IEC_DONE:
            state <= iec_pkg::IEC_DONE;
          default:
            state <= iec_pkg::IEC_IDLE;
        endcase
    end

  assign o_spi_sdo_oe = rd & (state == iec_pkg::IEC_DATA);
endmodule // iec_spi_port
`default_nettype wire

// >>> tb/iec_source.sv
// stand-in for the baseband source driving both double-rate ports
`timescale 1ns/1ps
`default_nettype none
module iec_source (
  input  wire logic        i_run,
  input  wire logic [63:0] i_a,
  input  wire logic [63:0] i_b,
  output logic             o_dclk,
  output logic      [15:0] o_a,
  output logic      [15:0] o_b
);
  initial
  begin
    o_dclk = 1'b0;
    o_a = 16'h0000;
    o_b = 16'h0000;
    forever
    begin
      wait (i_run);
      // data moves mid half-period, 40 ns clear of each edge
      for (int k = 0; k < 4; k++)
      begin
        o_a = i_a[16*k +: 16];
        o_b = i_b[16*k +: 16];
        #40 o_dclk = ~o_dclk;
        #40;
      end
      // released lines must not repeat the last word
      if (!i_run)
      begin
        o_a = ~o_a;
        o_b = ~o_b;
      end
    end
  end
endmodule // iec_source
`default_nettype wire

// >>> tb/testbench.sv
// self-checking bench for the sample error checker
`timescale 1ns/1ps
`default_nettype none
`include "iec_params.svh"
module testbench;
  typedef struct {logic [63:0] ea; logic [63:0] eb; logic [7:0] st;} iec_row_s;
  localparam logic [63:0] PA = 64'h0f0f_a5a5_1234_8001;
  localparam logic [63:0] PB = 64'hc3c3_5a5a_fedc_7ffe;
  logic        clk, rst, run, sel, sck, cs_n, sdi, sdo, dclk, oe;
  logic [63:0] da, db, w;
  logic [15:0] pa, pb;
  logic [7:0]  q;
  int          mismatches, n_tests;
  iec_row_s    rows [4];

  iec_source i_iec_source (.i_run(run), .i_a(da), .i_b(db), .o_dclk(dclk),
    .o_a(pa), .o_b(pb));
  iec_checker i_iec_checker (.i_sys_clk(clk), .i_reset(rst),
    .i_input_data_clock(dclk), .i_port_a_data(pa), .i_port_b_data(pb),
    .i_port_select(sel), .i_spi_clk(sck), .i_spi_cs_n(cs_n),
    .i_spi_sdi(sdi), .o_spi_sdo(sdo), .o_spi_sdo_oe(oe));

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic results();
    $display("comparisons %0d, mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      mismatches++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // slow serial clock holds each level for 8 system clock cycles, well above the minimum
  task automatic xfer(input logic rw, input logic [6:0] a,
    input logic [7:0] d);
    logic [15:0] f;
    f = {rw, a, d};
    @(posedge clk) #1 cs_n = 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      sdi = f[i];
      #40 sck = 1'b1;
      if (i < 8) q[i] = sdo;
      if (i == 4) chk({7'h00, oe}, {7'h00, rw});
      #40 sck = 1'b0;
    end
    #40 cs_n = 1'b1;
    #40;
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    xfer(1'b1, a, 8'h00);
    chk(q, exp);
  endtask

  task automatic port(input logic p);
    @(posedge clk) #1 sel = p;
    repeat (4) @(posedge clk);
  endtask

  // run exactly n sets, lowering run just before the next set starts
  task automatic sets(input logic [63:0] ea, eb, input int n);
    @(posedge clk) #1 da = PA ^ ea;
    db = PB ^ eb;
    run = 1'b1;
    #(320 * n - 10) run = 1'b0;
    #400;
  endtask

  task automatic maps(input logic [63:0] ea, eb);
    for (int p = 0; p < 2; p++)
    begin
      w = p ? eb : ea;
      port(p[0]);
      rd(`IEC_ADDR_MAP_R_LO, w[7:0] | w[39:32]);
      rd(`IEC_ADDR_MAP_R_HI, w[15:8] | w[47:40]);
      rd(`IEC_ADDR_MAP_F_LO, w[23:16] | w[55:48]);
      rd(`IEC_ADDR_MAP_F_HI, w[31:24] | w[63:56]);
    end
  endtask

  initial
  begin
    #400000;
    mismatches++;
    results();
  end

  initial
  begin
    rst = 1'b1;
    run = 1'b0;
    sel = 1'b0;
    sck = 1'b0;
    cs_n = 1'b1;
    sdi = 1'b0;
    da = PA;
    db = PB;
    q = 8'h00;
    mismatches = 0;
    n_tests = 0;
    repeat (20) @(posedge clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk);
    rd(`IEC_ADDR_CTL, `IEC_CTL_RESET);
    rd(`IEC_ADDR_PAT_BASE, 8'h00);
    rd(7'h45, 8'h00);
    xfer(1'b0, `IEC_ADDR_MAP_R_LO, 8'hff);
    maps(64'h0, 64'h0);
    $display("test reset done");
    for (int p = 0; p < 2; p++)
    begin
      port(p[0]);
      w = p ? PB : PA;
      for (int k = 0; k < 8; k++)
        xfer(1'b0, `IEC_ADDR_PAT_BASE + 7'(k), w[8*k +: 8]);
    end
    rd(7'h3b, PB[31:24]);
    port(1'b0);
    rd(7'h3b, PA[31:24]);
    $display("test patterns done");
    rows[0] = '{64'h0, 64'h0, 8'h81};
    rows[1] = '{64'h1, 64'h0, 8'ha2};
    rows[2] = '{64'h0, 64'h8000_0000_0000_0000, 8'hc4};
    rows[3] = '{64'h0000_0000_00f0_0000, 64'h0000_0100_0000_0000, 8'he6};
    foreach (rows[r])
    begin
      xfer(1'b0, `IEC_ADDR_CTL, 8'h00);
      xfer(1'b0, `IEC_ADDR_CTL, 8'h80);
      sets(rows[r].ea, rows[r].eb, 2);
      rd(`IEC_ADDR_CTL, rows[r].st);
      maps(rows[r].ea, rows[r].eb);
      $display("test row %0d done", r);
    end
    xfer(1'b0, `IEC_ADDR_CTL, 8'h00);
    sets(64'h1, 64'h1, 1);
    rd(`IEC_ADDR_CTL, 8'h00);
    maps(64'h0, 64'h0);
    $display("test disabled done");
    xfer(1'b0, `IEC_ADDR_CTL, 8'h80);
    sets(64'h1, 64'h0, 1);
    sets(64'h0, 64'h0, 1);
    rd(`IEC_ADDR_CTL, 8'ha1);
    maps(64'h1, 64'h0);
    $display("test sticky done");
    xfer(1'b0, `IEC_ADDR_CTL, 8'h00);
    xfer(1'b0, `IEC_ADDR_CTL, 8'h88);
    sets(64'h1, 64'h0, 1);
    sets(64'h0, 64'h0, 7);
    rd(`IEC_ADDR_CTL, 8'ha9);
    sets(64'h0, 64'h0, 1);
    rd(`IEC_ADDR_CTL, 8'h89);
    maps(64'h0, 64'h0);
    $display("test auto clear done");
    sets(64'h1, 64'h0, 1);
    rd(`IEC_ADDR_CTL, 8'haa);
    @(posedge clk) #1 rst = 1'b1;
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    repeat (4) @(posedge clk);
    rd(`IEC_ADDR_CTL, `IEC_CTL_RESET);
    rd(`IEC_ADDR_PAT_BASE + 7'h7, 8'h00);
    maps(64'h0, 64'h0);
    $display("test mid-run reset done");
    results();
  end
endmodule // testbench
`default_nettype wire
